// ===== src/sai_pkg.sv
// Package of constants for the servant address, interrupt and fault block
package sai_pkg;
  // ------------------------------------------------------------------
  // Register map (byte offsets on the AHB-Lite slave)
  // ------------------------------------------------------------------
  localparam logic [7:0] SAI_OFF_CTRL = 8'h00;
  localparam logic [7:0] SAI_OFF_STAT = 8'h04;
  localparam logic [7:0] SAI_OFF_IRQ_STAT = 8'h08;
  localparam logic [7:0] SAI_OFF_IRQ_MASK = 8'h0c;
  localparam logic [7:0] SAI_OFF_TRIG_OUT = 8'h10;
  localparam logic [7:0] SAI_OFF_TRIG_MON = 8'h14;
  localparam logic [7:0] SAI_OFF_EVENT = 8'h18;
  localparam logic [7:0] SAI_OFF_SER_OUT = 8'h1c;
  localparam logic [7:0] SAI_OFF_SER_ID = 8'h20;
  localparam logic [7:0] SAI_OFF_BASE = 8'h24;

  // ------------------------------------------------------------------
  // Control register fields
  // ------------------------------------------------------------------
  localparam int SAI_CTRL_FASTHS = 0;
  localparam int SAI_CTRL_SER_GO = 1;

  // ------------------------------------------------------------------
  // Interrupt status bits
  // ------------------------------------------------------------------
  localparam int SAI_IRQ_NBITS = 4;
  localparam int SAI_IRQ_FUSE = 0;
  localparam int SAI_IRQ_TRIG = 1;
  localparam int SAI_IRQ_SER = 2;
  localparam int SAI_IRQ_PROTO = 3;

  // ------------------------------------------------------------------
  // Window decode and interrupt level constants
  // ------------------------------------------------------------------
  localparam logic [15:0] SAI_WIN_BASE = 16'hc000;
  localparam logic [1:0] SAI_WIN_TOP = 2'b11;
  localparam int SAI_WIN_SHIFT = 6;
  localparam logic [3:0] SAI_LVL_OFF_HI = 4'h8;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int SAI_CLK_HZ = 10_000_000;
  localparam int SAI_SER_HZ = 1_000_000;
  localparam int SAI_SER_DIV = SAI_CLK_HZ / SAI_SER_HZ;

  typedef enum logic [1:0] {
    SAI_SER_IDLE = 2'b00,
    SAI_SER_SHIFT = 2'b01,
    SAI_SER_DONE = 2'b11
  } sai_ser_state_t;
endpackage

// ===== src/sai_sync.sv
// Two-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps
module sai_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

// ===== src/sai_top.sv
// Servant address decode, interrupter, fault and trigger block
`timescale 1ns/1ps

module sai_top
  import sai_pkg::*;
#(
  parameter int N_SLAVES = 12,
  parameter int N_TRIG = 8,
  parameter int SER_BITS = 16
) (
  input wire logic clk,
  input wire logic reset,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic irq,
  // Switches
  input wire logic [3:0] address_high_digit_switch,
  input wire logic [3:0] address_low_digit_switch,
  input wire logic [3:0] irq_level_switch,
  // Backplane short-address decode
  input wire logic [15:0] bp_addr,
  input wire logic bp_short_access,
  output logic bp_selected,
  output logic [4:0] bp_reg_sel,
  output logic [15:0] bp_base_addr,
  output logic la_valid,
  // Backplane interrupt request lines, active low, open drain
  output logic [7:1] bp_irq_n_oe,
  // Fault and failure line
  input wire logic [N_SLAVES-1:0] slave_fuse_open,
  input wire logic host_fuse_open,
  input wire logic sysfail_inhibit,
  output logic sysfail_n_o,
  output logic sysfail_n_oe,
  // Trigger lines, active low, open drain
  input wire logic [N_TRIG-1:0] trig_n_i,
  output logic [N_TRIG-1:0] trig_n_o,
  output logic [N_TRIG-1:0] trig_n_oe,
  output logic fast_handshake_en,
  // Serial local bus
  output logic ser_clk,
  output logic ser_dout,
  output logic ser_load,
  input wire logic ser_id_in
);
  initial begin
    if (N_TRIG < 1 || N_TRIG > 8) $error("N_TRIG must be 1 to 8");
    if (N_SLAVES < 1 || N_SLAVES > 32) $error("N_SLAVES out of range");
    if (SER_BITS < 1 || SER_BITS > 32) $error("SER_BITS out of range");
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam int NS = 12 + N_SLAVES + 3 + N_TRIG + 1;
  logic [NS-1:0] pins_s;
  logic [3:0] address_high_digit_switch_s;
  logic [3:0] address_low_digit_switch_s;
  logic [3:0] lvl_s;
  logic [N_SLAVES-1:0] fuse_s;
  logic host_fuse_s;
  logic inhibit_s;
  logic short_s;
  logic [N_TRIG-1:0] trig_s;
  logic ser_id_s;

  // Trigger lines enter inverted: the synchroniser resets to zero, which
  // must read as idle or a false edge follows reset
  sai_sync #(.WIDTH(NS)) u_sync (
    .clk(clk),
    .reset(reset),
    .async_in({address_high_digit_switch, address_low_digit_switch,
               irq_level_switch, slave_fuse_open, host_fuse_open,
               sysfail_inhibit, bp_short_access, ~trig_n_i, ser_id_in}),
    .sync_out(pins_s)
  );
  assign {address_high_digit_switch_s, address_low_digit_switch_s, lvl_s, fuse_s, host_fuse_s, inhibit_s,
          short_s, trig_s, ser_id_s} = pins_s;

  // ----------------------------------------------------------------
  // Logical address and window decode
  // ----------------------------------------------------------------
  wire [7:0] log_addr = {address_high_digit_switch_s, address_low_digit_switch_s};
  wire la_ok = (log_addr != 8'h00);
  wire [15:0] base_w = SAI_WIN_BASE +
                       (16'({8'h00, log_addr}) << SAI_WIN_SHIFT);
  // Address bit 15:14 are fixed 11, then the address byte
  wire win_hit = (bp_addr[15:14] == SAI_WIN_TOP) &&
                 (bp_addr[13:6] == log_addr);
  // Bus address is sampled raw with the strobe synchronised
  logic sel_q;
  logic [4:0] rsel_q;
  logic [15:0] base_q;
  always_ff @(posedge clk) begin
    if (reset) begin
      sel_q <= 1'b0;
      rsel_q <= 5'h00;
      base_q <= SAI_WIN_BASE;
    end else begin
      sel_q <= short_s && win_hit && la_ok;
      rsel_q <= bp_addr[5:1];
      base_q <= base_w;
    end
  end
  assign bp_selected = sel_q;
  assign bp_reg_sel = rsel_q;
  assign bp_base_addr = base_q;
  assign la_valid = la_ok;

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [7:0] rd_addr_q;
  logic rd_pend_q;
  wire ahb_go = hsel && hready && htrans[1];
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      rd_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= ahb_go && hwrite;
      rd_pend_q <= ahb_go && !hwrite;
      wr_addr_q <= haddr[7:0];
      rd_addr_q <= haddr[7:0];
    end
  end
  // Reads take one wait state so hrdata stands in the last data cycle
  assign hreadyout = !rd_pend_q;
  assign hresp = 1'b0;
  wire wr_ctrl = wr_pend_q && (wr_addr_q == SAI_OFF_CTRL);
  wire wr_istat = wr_pend_q && (wr_addr_q == SAI_OFF_IRQ_STAT);
  wire wr_imask = wr_pend_q && (wr_addr_q == SAI_OFF_IRQ_MASK);
  wire wr_trig = wr_pend_q && (wr_addr_q == SAI_OFF_TRIG_OUT);
  wire wr_event = wr_pend_q && (wr_addr_q == SAI_OFF_EVENT);
  wire wr_ser = wr_pend_q && (wr_addr_q == SAI_OFF_SER_OUT);

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  logic fasths_q;
  logic [SAI_IRQ_NBITS-1:0] imask_q;
  logic [N_TRIG-1:0] trig_drv_q;
  logic [SER_BITS-1:0] ser_tx_q;
  always_ff @(posedge clk) begin
    if (reset) begin
      fasths_q <= 1'b0;
      imask_q <= '0;
      trig_drv_q <= '0;
      ser_tx_q <= '0;
    end else begin
      if (wr_ctrl) fasths_q <= hwdata[SAI_CTRL_FASTHS];
      if (wr_imask) imask_q <= hwdata[SAI_IRQ_NBITS-1:0];
      if (wr_trig) trig_drv_q <= hwdata[N_TRIG-1:0];
      if (wr_ser) ser_tx_q <= hwdata[SER_BITS-1:0];
    end
  end
  assign fast_handshake_en = fasths_q;

  // Trigger lines are pulled low only where a driver bit is set
  assign trig_n_o = '0;
  assign trig_n_oe = trig_drv_q;

  // ----------------------------------------------------------------
  // Trigger monitor: falling edge of any line raises an event
  // ----------------------------------------------------------------
  logic [N_TRIG-1:0] trig_prev_q;
  always_ff @(posedge clk) begin
    if (reset) trig_prev_q <= '0;
    else trig_prev_q <= trig_s;
  end
  // Synchronised lines are active high here
  wire trig_edge = |(trig_s & ~trig_prev_q);

  // ----------------------------------------------------------------
  // Serial local bus: shift out control word, shift in identity
  // ----------------------------------------------------------------
  sai_ser_state_t ser_st_q;
  logic [7:0] div_q;
  logic [5:0] bit_q;
  logic [SER_BITS-1:0] sh_out_q;
  logic [SER_BITS-1:0] sh_in_q;
  logic [SER_BITS-1:0] ser_rx_q;
  logic sclk_q;
  wire tick = (div_q == 8'(SAI_SER_DIV / 2 - 1));
  wire ser_start = wr_ctrl && hwdata[SAI_CTRL_SER_GO];
  wire ser_done = (ser_st_q == SAI_SER_DONE);
  always_ff @(posedge clk) begin
    if (reset || ser_st_q == SAI_SER_IDLE || tick) div_q <= 8'h00;
    else div_q <= div_q + 8'h01;
  end
  // Data changes on falling ser_clk, slaves sample on rising
  always_ff @(posedge clk) begin
    if (reset) begin
      ser_st_q <= SAI_SER_IDLE;
      bit_q <= 6'h00;
      sh_out_q <= '0;
      sh_in_q <= '0;
      ser_rx_q <= '0;
      sclk_q <= 1'b0;
    end else begin
      case (ser_st_q)
        SAI_SER_IDLE: begin
          sclk_q <= 1'b0;
          if (ser_start) begin
            sh_out_q <= ser_tx_q;
            bit_q <= 6'h00;
            ser_st_q <= SAI_SER_SHIFT;
          end
        end
        SAI_SER_SHIFT: begin
          if (tick) begin
            sclk_q <= !sclk_q;
            if (!sclk_q) begin
              sh_in_q <= {sh_in_q[SER_BITS-2:0], ser_id_s};
            end else begin
              sh_out_q <= {sh_out_q[SER_BITS-2:0], 1'b0};
              bit_q <= bit_q + 6'h01;
              if (bit_q == 6'(SER_BITS - 1)) ser_st_q <= SAI_SER_DONE;
            end
          end
        end
        SAI_SER_DONE: begin
          ser_rx_q <= sh_in_q;
          ser_st_q <= SAI_SER_IDLE;
        end
        default: ser_st_q <= SAI_SER_IDLE;
      endcase
    end
  end
  assign ser_clk = sclk_q;
  assign ser_dout = sh_out_q[SER_BITS-1];
  assign ser_load = ser_done;

  // ----------------------------------------------------------------
  // System failure line
  // ----------------------------------------------------------------
  wire any_fuse = |fuse_s || host_fuse_s;
  // Host supply loss overrides the inhibit request
  wire fail_drive = host_fuse_s || (any_fuse && !inhibit_s);
  logic fail_q;
  logic fuse_prev_q;
  always_ff @(posedge clk) begin
    if (reset) begin
      fail_q <= 1'b0;
      fuse_prev_q <= 1'b0;
    end else begin
      fail_q <= fail_drive;
      fuse_prev_q <= any_fuse;
    end
  end
  assign sysfail_n_o = 1'b0;
  assign sysfail_n_oe = fail_q;

  // ----------------------------------------------------------------
  // Interrupt status, mask and level output
  // ----------------------------------------------------------------
  logic [SAI_IRQ_NBITS-1:0] istat_q;
  logic [SAI_IRQ_NBITS-1:0] ev_set;
  always_comb begin
    ev_set = '0;
    ev_set[SAI_IRQ_FUSE] = any_fuse && !fuse_prev_q;
    ev_set[SAI_IRQ_TRIG] = trig_edge;
    ev_set[SAI_IRQ_SER] = ser_done;
    ev_set[SAI_IRQ_PROTO] = wr_event && hwdata[0];
  end
  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge clk) begin
    if (reset) istat_q <= '0;
    else istat_q <= (istat_q & ~(wr_istat ? hwdata[SAI_IRQ_NBITS-1:0]
                                          : '0)) | ev_set;
  end
  wire irq_pend = |(istat_q & imask_q);
  assign irq = irq_pend;
  wire lvl_on = (lvl_s != 4'h0) && (lvl_s < SAI_LVL_OFF_HI);
  genvar gl;
  generate
    for (gl = 1; gl <= 7; gl++) begin : g_lvl
      // Open-drain request on the selected level only
      assign bp_irq_n_oe[gl] = irq_pend && lvl_on &&
                               (lvl_s == 4'(gl));
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  logic [31:0] rd_d;
  always_comb begin
    rd_d = 32'h0000_0000;
    case (rd_addr_q)
      SAI_OFF_CTRL: rd_d[SAI_CTRL_FASTHS] = fasths_q;
      SAI_OFF_STAT: rd_d = {16'h0000, 4'h0, lvl_s, log_addr} |
                           {3'b000, ser_st_q != SAI_SER_IDLE,
                            la_ok, host_fuse_s, inhibit_s, fail_q,
                            24'h00_0000};
      SAI_OFF_IRQ_STAT: rd_d[SAI_IRQ_NBITS-1:0] = istat_q;
      SAI_OFF_IRQ_MASK: rd_d[SAI_IRQ_NBITS-1:0] = imask_q;
      SAI_OFF_TRIG_OUT: rd_d[N_TRIG-1:0] = trig_drv_q;
      SAI_OFF_TRIG_MON: rd_d[N_TRIG-1:0] = trig_s;
      SAI_OFF_SER_OUT: rd_d[SER_BITS-1:0] = ser_tx_q;
      SAI_OFF_SER_ID: rd_d[SER_BITS-1:0] = ser_rx_q;
      SAI_OFF_BASE: rd_d[15:0] = base_q;
      default: rd_d = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge clk) begin
    if (reset) hrdata <= 32'h0000_0000;
    else if (ahb_go && !hwrite) hrdata <= 32'h0000_0000;
    else if (rd_pend_q) hrdata <= rd_d;
  end
endmodule

// ===== tb/sai_top_properties.sv
// Checker of the address, interrupter and fault outputs
`timescale 1ns/1ps
module sai_top_properties #(
  parameter int N_SLAVES = 12,
  parameter int N_TRIG = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [3:0] address_high_digit_switch,
  input wire logic [3:0] address_low_digit_switch,
  input wire logic [3:0] irq_level_switch,
  input wire logic irq,
  input wire logic bp_selected,
  input wire logic la_valid,
  input wire logic [15:0] bp_base_addr,
  input wire logic [7:1] bp_irq_n_oe,
  input wire logic [N_SLAVES-1:0] slave_fuse_open,
  input wire logic host_fuse_open,
  input wire logic sysfail_inhibit,
  input wire logic sysfail_n_o,
  input wire logic sysfail_n_oe,
  input wire logic [N_TRIG-1:0] trig_n_o,
  input wire logic ser_load
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Switch digits joined; repeat counts cover the synchroniser delay
  wire [7:0] la = {address_high_digit_switch, address_low_digit_switch};
  wire lvl_on = irq_level_switch inside {[1:7]};
  // ----------------------------------------------------------------
  // Window decode
  // ----------------------------------------------------------------
  AST_BASE: assert property ($stable(la)[*5] |->
    bp_base_addr == 16'hc000 + {2'b00, la, 6'h00}) else $error("bad base");
  AST_ALIGN: assert property (bp_base_addr[5:0] == 6'h00 &&
    bp_base_addr[15:14] == 2'b11) else $error("base not aligned");
  AST_LA_VALID: assert property ($stable(la)[*4] |->
    la_valid == (la != 8'h00)) else $error("bad la_valid");
  AST_SEL: assert property (bp_selected |-> la_valid)
    else $error("selected with address zero");
  // ----------------------------------------------------------------
  // Interrupter, fault, trigger and serial load lines
  // ----------------------------------------------------------------
  AST_LVL_OFF: assert property ((!lvl_on)[*4] |->
    bp_irq_n_oe == 7'h00) else $error("level off but driving");
  AST_LVL_ON: assert property ((lvl_on && irq &&
    $stable(irq_level_switch))[*4] |->
    bp_irq_n_oe[irq_level_switch[2:0]]) else $error("wrong level");
  AST_ONEHOT: assert property ($onehot0(bp_irq_n_oe))
    else $error("several levels driven");
  AST_QUIET: assert property ((!irq)[*3] |-> bp_irq_n_oe == 7'h00)
    else $error("request without event");
  AST_HOST: assert property (host_fuse_open[*5] |-> sysfail_n_oe)
    else $error("host fuse not failing");
  AST_FUSE: assert property ((slave_fuse_open != '0 &&
    !sysfail_inhibit)[*5] |-> sysfail_n_oe) else $error("fuse missed");
  AST_RELEASE: assert property ((sysfail_inhibit &&
    !host_fuse_open)[*5] |-> !sysfail_n_oe) else $error("not released");
  AST_OD: assert property (sysfail_n_o == 1'b0 && trig_n_o == '0)
    else $error("open drain data not low");
  AST_LOAD: assert property (ser_load |=> !ser_load)
    else $error("load pulse too long");
  // Main scenarios reached
  cover property (bp_selected);
  cover property (sysfail_n_oe && sysfail_inhibit);
  cover property (ser_load);
  cover property (bp_irq_n_oe[7]);
endmodule

// ===== tb/sai_bp_model.sv
// Backplane commander and resource manager model
`timescale 1ns/1ps
module sai_bp_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic sysfail_n_oe,
  input wire logic [7:0] trig_n_oe,
  input wire logic [7:0] far_trig,
  input wire logic inhibit_en,
  input wire logic [3:0] inhibit_delay,
  output logic sysfail_inhibit,
  output logic [7:0] trig_wire_n
);
  logic [3:0] wait_q;
  // Pulled-up trigger lines: low while any party pulls them
  assign trig_wire_n = ~(trig_n_oe | far_trig);
  // Inhibit a seen failure after a set delay; held so it cannot ring
  always @(posedge clk) begin
    if (reset || !inhibit_en) begin
      wait_q <= 4'h0;
      sysfail_inhibit <= 1'b0;
    end else if (sysfail_n_oe && wait_q != inhibit_delay) begin
      wait_q <= wait_q + 4'h1;
    end else if (wait_q == inhibit_delay) begin
      sysfail_inhibit <= 1'b1;
    end
  end
endmodule

// ===== tb/sai_top_tb.sv
// Testbench of the servant address, interrupt and fault block
`timescale 1ns/1ps
module sai_top_tb;
  import sai_pkg::*;
  logic clk = 0, reset = 1, hsel = 0, hwrite = 0;
  logic [31:0] haddr = 0, hwdata = 0, rd;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic [3:0] sw_hi = 0, sw_lo = 1, lvl = 0, idly = 4'h3;
  logic [15:0] bp_addr = 0, shift_q;
  logic bp_short_access = 0, host_fuse_open = 0, inhibit_en = 0;
  logic ser_id_in = 1, prev_clk;
  logic [11:0] slave_fuse_open = 0;
  logic [7:0] far_trig = 0, la_e;
  logic [4:0] rs;
  wire hreadyout, hresp, irq, bp_selected, la_valid, sysfail_n_o;
  wire sysfail_n_oe, sysfail_inhibit, fast_handshake_en;
  wire ser_clk, ser_dout, ser_load;
  wire [31:0] hrdata;
  wire [4:0] bp_reg_sel;
  wire [15:0] bp_base_addr;
  wire [7:1] bp_irq_n_oe;
  wire [7:0] trig_n_i, trig_n_o, trig_n_oe;
  int failures = 0, compares = 0, n;
  // Address rows: high digit, low digit, register select
  logic [12:0] rows [6] = '{{4'h0, 4'h1, 5'h00}, {4'h0, 4'ha, 5'h1f},
    {4'h1, 4'h5, 5'h02}, {4'hf, 4'hf, 5'h10}, {4'h8, 4'h0, 5'h05},
    {4'h0, 4'h0, 5'h01}};

  sai_top sai_top_i (.clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .irq,
    .address_high_digit_switch(sw_hi), .address_low_digit_switch(sw_lo),
    .irq_level_switch(lvl), .bp_addr, .bp_short_access, .bp_selected,
    .bp_reg_sel, .bp_base_addr, .la_valid, .bp_irq_n_oe, .slave_fuse_open,
    .host_fuse_open, .sysfail_inhibit, .sysfail_n_o, .sysfail_n_oe,
    .trig_n_i, .trig_n_o, .trig_n_oe, .fast_handshake_en, .ser_clk,
    .ser_dout, .ser_load, .ser_id_in);
  sai_bp_model sai_bp_model_i (.clk, .reset, .sysfail_n_oe, .trig_n_oe,
    .far_trig, .inhibit_en, .inhibit_delay(idly), .sysfail_inhibit,
    .trig_wire_n(trig_n_i));

  // 10 MHz clock
  initial begin
    forever #50 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task print_verdict;
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task tick(input int c);
    repeat (c) @(posedge clk);
  endtask
  // Bounded wait for hready; a hang ends the run
  task hwait;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      failures++;
      print_verdict;
    end
  endtask
  // One word transfer; read data is taken at the edge that ends it
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    hwait;
    hsel <= 0;
    htrans <= 2'b00;
    hwdata <= d;
    hwait;
    rd = hrdata;
    // One idle cycle lets a write land before the caller looks
    @(posedge clk);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    tick(16);
    reset <= 0;
    tick(3);
    // Decode rows, then a neighbour address that must not select
    foreach (rows[i]) begin
      {sw_hi, sw_lo} <= rows[i][12:5];
      la_e = rows[i][12:5];
      rs = rows[i][4:0];
      tick(6);
      chk(32'(bp_base_addr), 32'hc000 + {la_e, 6'h00});
      chk(32'(la_valid), 32'(la_e != 8'h00));
      bp_addr <= {2'b11, la_e, rs, 1'b0};
      bp_short_access <= 1;
      tick(5);
      chk(32'(bp_selected), 32'(la_e != 8'h00));
      if (la_e != 8'h00) chk(32'(bp_reg_sel), 32'(rs));
      bp_addr <= {2'b11, la_e ^ 8'h01, rs, 1'b0};
      tick(5);
      chk(32'(bp_selected), 32'h0);
      bp_short_access <= 0;
      tick(4);
    end
    // Protocol event raised, every level setting swept
    bus(1, SAI_OFF_IRQ_MASK, 32'h8);
    bus(1, SAI_OFF_EVENT, 32'h1);
    chk(32'(irq), 32'h1);
    for (int l = 0; l < 16; l++) begin
      lvl <= 4'(l);
      tick(6);
      chk(32'(bp_irq_n_oe), (l >= 1 && l <= 7) ? (32'h1 << l) >> 1 : 0);
    end
    lvl <= 4'h3;
    bus(1, SAI_OFF_IRQ_MASK, 32'h0);
    tick(3);
    chk(32'(bp_irq_n_oe), 32'h0);
    bus(1, SAI_OFF_IRQ_MASK, 32'h8);
    bus(1, SAI_OFF_IRQ_STAT, 32'h8);
    bus(0, SAI_OFF_IRQ_STAT, 32'h0);
    chk(rd, 32'h0);
    chk(32'(irq), 32'h0);
    // Unmapped place reads zero and ignores writes
    bus(1, 8'h30, 32'hffff_ffff);
    bus(0, 8'h30, 32'h0);
    chk(rd, 32'h0);
    bus(1, SAI_OFF_CTRL, 32'h1);
    chk(32'(fast_handshake_en), 32'h1);
    bus(1, SAI_OFF_CTRL, 32'h0);
    chk(32'(fast_handshake_en), 32'h0);
    // Triggers driven by us and by the far side together
    bus(1, SAI_OFF_TRIG_OUT, 32'ha5);
    chk(32'(trig_n_oe), 32'ha5);
    far_trig <= 8'h0f;
    tick(4);
    bus(0, SAI_OFF_TRIG_MON, 32'h0);
    chk(rd, 32'haf);
    bus(0, SAI_OFF_IRQ_STAT, 32'h0);
    chk(rd, 32'h2);
    bus(1, SAI_OFF_TRIG_OUT, 32'h0);
    far_trig <= 8'h00;
    bus(1, SAI_OFF_IRQ_STAT, 32'hf);
    // Slave fuse, inhibit release, then host fuse defeats inhibit
    slave_fuse_open <= 12'h008;
    tick(6);
    chk(32'(sysfail_n_oe), 32'h1);
    inhibit_en <= 1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (sysfail_n_oe !== 1'b0 && n < 40);
    chk(32'(sysfail_n_oe), 32'h0);
    host_fuse_open <= 1;
    tick(6);
    chk(32'(sysfail_n_oe), 32'h1);
    {host_fuse_open, inhibit_en} <= 2'b00;
    slave_fuse_open <= 12'h000;
    tick(6);
    chk(32'(sysfail_n_oe), 32'h0);
    // Serial frame out, bits caught on each serial clock rise
    bus(1, SAI_OFF_SER_OUT, 32'hc3a5);
    bus(1, SAI_OFF_CTRL, 32'h2);
    n = 0;
    prev_clk = ser_clk;
    while (ser_load !== 1'b1 && n < 600) begin
      @(posedge clk);
      n++;
      if (ser_clk === 1'b1 && prev_clk === 1'b0)
        shift_q = {shift_q[14:0], ser_dout};
      prev_clk = ser_clk;
      // Slave echoes the control stream back as its identity
      ser_id_in <= ser_dout;
    end
    chk(32'(shift_q), 32'hc3a5);
    tick(2);
    bus(0, SAI_OFF_SER_ID, 32'h0);
    chk(rd, 32'hc3a5);
    // Mid-run reset clears registers and pending events
    bus(1, SAI_OFF_IRQ_MASK, 32'hf);
    bus(1, SAI_OFF_TRIG_OUT, 32'h3c);
    chk(32'(irq), 32'h1);
    reset <= 1;
    tick(2);
    chk(32'(irq), 32'h0);
    chk(32'(trig_n_oe), 32'h0);
    reset <= 0;
    tick(3);
    bus(0, SAI_OFF_IRQ_STAT, 32'h0);
    chk(rd, 32'h0);
    print_verdict;
  end
endmodule

bind sai_top sai_top_properties #(.N_SLAVES(N_SLAVES), .N_TRIG(N_TRIG))
  sai_top_properties_i (.*);
